//--- include/pwm_pkg.sv
// Package: register map, field positions and reset values of the
// six-module compare/PWM block.
// Assumes an 8-bit special-function-register bus with byte addresses.
package pwm_pkg;
   localparam int          NUM_MOD        = 6;
   localparam int          CNT_W          = 16;
   // Register addresses; per-module registers start at the base + n
   localparam logic [7:0]  ADDR_DEADBAND  = 8'hBC;
   localparam logic [7:0]  ADDR_CTRL      = 8'hD8;
   localparam logic [7:0]  ADDR_MODE      = 8'hDA;
   localparam logic [7:0]  ADDR_CMP_LO    = 8'hEA;
   localparam logic [7:0]  ADDR_AUX       = 8'hF2;
   localparam logic [7:0]  ADDR_CMP_HI    = 8'hFA;
   // Reset values
   localparam logic [7:0]  RST_REG        = 8'h00;
   // module_mode fields
   localparam int          MM_DEADBAND    = 7;
   localparam int          MM_COMPARATOR  = 6;
   localparam int          MM_MATCH_FLAG  = 3;
   localparam int          MM_TOGGLE      = 2;
   localparam int          MM_PULSE       = 1;
   localparam int          MM_IRQ         = 0;
   localparam logic [7:0]  MM_WMASK       = 8'hCF;
   // pulse_aux fields
   localparam int          AUX_RES_HI     = 7;
   localparam int          AUX_RES_LO     = 6;
   localparam int          AUX_INVERT     = 2;
   localparam int          AUX_RELOAD9    = 1;
   localparam int          AUX_ACTIVE9    = 0;
   localparam logic [7:0]  AUX_WMASK      = 8'hC7;
   // Resolution codes
   localparam logic [1:0]  RES_8          = 2'h0;
   localparam logic [1:0]  RES_10         = 2'h1;
   localparam logic [1:0]  RES_12         = 2'h2;
   localparam logic [1:0]  RES_16         = 2'h3;
   // deadband_control fields
   localparam int          DB_PS_HI       = 7;
   localparam int          DB_PS_LO       = 6;
   localparam int          DB_LEN_HI      = 5;
   localparam int          DB_LEN_LO      = 0;
endpackage

//--- core/pwm_six.sv
// Six compare/PWM modules on one shared base counter, with their
// register file on the special-function-register bus.
// Assumes the base counter, its overflow and the manual reload strobe
// come from logic on the same clock.
//
// Summary of operation
// - Dead band acts only on modules 0/2/4 with their pair buffer on.
// - Comparator enable turns a module's counter comparison on or off.
// - With match flag enable set, a match sets the module match flag.
// - With toggle enable set and PWM off, every match inverts the module output.
// - Pulse width enable puts the PWM waveform on the output pin.
// - Interrupt enable gates the flag onto the request; flag still sets.
// - Resolution 00/01/10/11 gives 8/10/12/16 bits; cycle ends on rollover.
// - Output invert presents the module result inverted or unchanged.
// - Two ninth bits extend reload and active compare bytes to 9 bits.
// - Mode decodes from comparator, match, toggle, PWM and pair buffer.
// - Software timer compares counter; flag plus enable raises interrupt.
// - Low compare write clears comparator enable; high write sets it.
// - Buffered pairs copy odd compare to even on overflow or strobe.
// - Odd low buffer writes in buffered mode do not inhibit comparator.
// - High-speed output toggles on every match with all three bits set and PWM off.
// - All modules share the base counter; equal resolutions give one PWM frequency.
// - 8-bit PWM is low while {0,low byte} is below the active value.
// - Low byte wrap reloads the active 9-bit value from the reload.
// - 8-bit duty equals one minus reload value over 256.
// - Each module runs 10/12/16-bit PWM at its own resolution.
// - Dead band length 0 disables, else that many prescaled periods.
// - Match flags set only by hardware, cleared only by software.
// - Pair buffer enable controls buffering for pairs 0/1, 2/3, 4/5.
`timescale 1ns/1ps

module pwm_six
   import pwm_pkg::*;
(
   input  wire logic                  mclk_in,
   input  wire logic                  rst_n_in,
   input  wire logic [7:0]            sfr_addr_in,
   input  wire logic [7:0]            sfr_wdata_in,
   input  wire logic                  sfr_wr_in,
   input  wire logic                  sfr_rd_in,
   output      logic [7:0]            sfr_rdata_out,
   input  wire logic [pwm_pkg::CNT_W-1:0] base_count_in,
   input  wire logic                  counter_overflow_in,
   input  wire logic                  manual_reload_strobe_in,
   input  wire logic [2:0]            pair_buffer_enable_in,
   input  wire logic [pwm_pkg::NUM_MOD-1:0] port_data_in,
   output      logic [pwm_pkg::NUM_MOD-1:0] module_output_pin_out,
   output      logic [2:0]            deadband_low_out,
   output      logic                  match_irq_out
);
   import pwm_pkg::*;

   // ***************************************************************
   // Shared state
   // ***************************************************************
   logic [CNT_W-1:0]   prev_count_ff;
   logic [NUM_MOD-1:0] match_flag_ff;
   logic [7:0]         deadband_ff;
   logic [2:0]         presc_ff;
   logic               presc_tick;
   logic               count_moved;
   logic               low_wrap;
   logic [NUM_MOD-1:0] match_v;
   logic [NUM_MOD-1:0] raw_v;
   logic [NUM_MOD-1:0] db_pin_v;
   logic [7:0]         mode_w  [NUM_MOD];
   logic [7:0]         clo_w   [NUM_MOD];
   logic [7:0]         chi_w   [NUM_MOD];
   logic [7:0]         aux_w   [NUM_MOD];
   logic [8:0]         act9_w  [NUM_MOD];
   logic [2:0]         db_low_v;

   // Counter moves are seen once, so a held count cannot re-match
   assign count_moved = base_count_in != prev_count_ff;
   assign low_wrap    = (prev_count_ff[7:0] == 8'hFF) &&
                        (base_count_in[7:0] == 8'h00);

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         prev_count_ff <= '0;
      end else begin
         prev_count_ff <= base_count_in;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         deadband_ff <= RST_REG;
      end else if (sfr_wr_in && sfr_addr_in == ADDR_DEADBAND) begin
         deadband_ff <= sfr_wdata_in;
      end
   end

   // Prescaler: tick every 1, 2, 4 or 8 clocks
   assign presc_tick = (presc_ff &
      3'((4'h1 << deadband_ff[DB_PS_HI:DB_PS_LO]) - 4'h1)) == 3'h0;

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         presc_ff <= 3'h0;
      end else begin
         presc_ff <= presc_ff + 3'h1;
      end
   end

   // Set wins over a software clear in the same cycle
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         match_flag_ff <= '0;
      end else if (sfr_wr_in && sfr_addr_in == ADDR_CTRL) begin
         match_flag_ff <= (match_flag_ff & sfr_wdata_in[5:0]) |
                          match_v;
      end else begin
         match_flag_ff <= match_flag_ff | match_v;
      end
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         match_irq_out <= 1'b0;
      end else begin
         match_irq_out <= 1'b0;
         for (int k = 0; k < NUM_MOD; k++) begin
            if (match_flag_ff[k] && mode_w[k][MM_IRQ]) begin
               match_irq_out <= 1'b1;
            end
         end
      end
   end

   // ***************************************************************
   // Per-module logic
   // ***************************************************************
   for (genvar n = 0; n < NUM_MOD; n++) begin : g_mod
      localparam int PAIR = n / 2;
      localparam bit ODD  = (n % 2) == 1;
      logic [7:0]       mode_ff;
      logic [7:0]       clo_ff;
      logic [7:0]       chi_ff;
      logic [7:0]       aux_ff;
      logic [8:0]       act9_ff;
      logic             tog_ff;
      logic             buffered;
      logic             copy_in;
      logic             wr_lo;
      logic             wr_hi;
      logic [CNT_W-1:0] mask;
      logic             wide_ge;
      logic             pwm_level;
      logic             res_wrap;

      assign buffered = pair_buffer_enable_in[PAIR];
      assign copy_in  = !ODD && buffered &&
                        (counter_overflow_in || manual_reload_strobe_in);
      assign wr_lo = sfr_wr_in && sfr_addr_in == ADDR_CMP_LO + 8'(n);
      assign wr_hi = sfr_wr_in && sfr_addr_in == ADDR_CMP_HI + 8'(n);

      always_ff @(posedge mclk_in or negedge rst_n_in) begin
         if (!rst_n_in) begin
            mode_ff <= RST_REG;
         end else if (sfr_wr_in && sfr_addr_in == ADDR_MODE + 8'(n)) begin
            mode_ff <= sfr_wdata_in & MM_WMASK;
         end else if (wr_lo && !(ODD && buffered)) begin
            mode_ff[MM_COMPARATOR] <= 1'b0;
         end else if (wr_hi) begin
            mode_ff[MM_COMPARATOR] <= 1'b1;
         end
      end

      // Even modules of a buffered pair take the odd partner's bytes
      if (!ODD) begin : g_even
         always_ff @(posedge mclk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               clo_ff <= RST_REG;
               chi_ff <= RST_REG;
            end else if (copy_in) begin
               clo_ff <= clo_w[n+1];
               chi_ff <= chi_w[n+1];
            end else begin
               if (wr_lo) clo_ff <= sfr_wdata_in;
               if (wr_hi) chi_ff <= sfr_wdata_in;
            end
         end
      end else begin : g_odd
         always_ff @(posedge mclk_in or negedge rst_n_in) begin
            if (!rst_n_in) begin
               clo_ff <= RST_REG;
               chi_ff <= RST_REG;
            end else begin
               if (wr_lo) clo_ff <= sfr_wdata_in;
               if (wr_hi) chi_ff <= sfr_wdata_in;
            end
         end
      end

      always_ff @(posedge mclk_in or negedge rst_n_in) begin
         if (!rst_n_in) begin
            aux_ff <= RST_REG;
         end else if (sfr_wr_in && sfr_addr_in == ADDR_AUX + 8'(n)) begin
            aux_ff <= sfr_wdata_in & AUX_WMASK;
         end
      end

      // Active value follows the reload value only at a low-byte wrap
      always_ff @(posedge mclk_in or negedge rst_n_in) begin
         if (!rst_n_in) begin
            act9_ff <= 9'h000;
         end else if (sfr_wr_in && sfr_addr_in == ADDR_CMP_LO + 8'(n)) begin
            act9_ff[7:0] <= sfr_wdata_in;
         end else if (sfr_wr_in && sfr_addr_in == ADDR_AUX + 8'(n)) begin
            act9_ff[8] <= sfr_wdata_in[AUX_ACTIVE9];
         end else if (low_wrap) begin
            act9_ff <= {aux_ff[AUX_RELOAD9], chi_ff};
         end
      end

      assign match_v[n] = mode_ff[MM_COMPARATOR] && count_moved &&
                          mode_ff[MM_MATCH_FLAG] &&
                          base_count_in == {chi_ff, clo_ff};
      assign res_wrap = count_moved && ((base_count_in & mask) == '0);

      // Toggle state; matches need the match bit as well as toggle
      always_ff @(posedge mclk_in or negedge rst_n_in) begin
         if (!rst_n_in) begin
            tog_ff <= 1'b0;
         end else if (match_v[n] && mode_ff[MM_TOGGLE] &&
                      !mode_ff[MM_PULSE]) begin
            tog_ff <= !tog_ff;
         end
      end

      always_comb begin
         case (aux_w[n][AUX_RES_HI:AUX_RES_LO])
            RES_8:   mask = 16'h00FF;
            RES_10:  mask = 16'h03FF;
            RES_12:  mask = 16'h0FFF;
            default: mask = 16'hFFFF;
         endcase
      end
      assign wide_ge = (base_count_in & mask) >=
                       {chi_ff, clo_ff};

      // Shared counter gives modules of equal resolution the same frequency
      always_comb begin
         if (aux_ff[AUX_RES_HI:AUX_RES_LO] == RES_8) begin
            pwm_level = {1'b0, base_count_in[7:0]} >=
                        act9_ff;
         end else begin
            pwm_level = wide_ge;
         end
      end

      always_comb begin
         if (mode_ff[MM_COMPARATOR] && mode_ff[MM_PULSE]) begin
            raw_v[n] = pwm_level ^ aux_ff[AUX_INVERT];
         end else if (mode_ff[MM_COMPARATOR] && mode_ff[MM_MATCH_FLAG] &&
                      mode_ff[MM_TOGGLE]) begin
            raw_v[n] = tog_ff ^ aux_ff[AUX_INVERT];
         end else begin
            raw_v[n] = port_data_in[n];
         end
      end

      assign mode_w[n] = mode_ff;
      assign clo_w[n]  = clo_ff;
      assign chi_w[n]  = chi_ff;
      assign aux_w[n]  = aux_ff;
      assign act9_w[n] = act9_ff;
   end

   // ***************************************************************
   // Dead band on even modules
   // ***************************************************************
   for (genvar p = 0; p < 3; p++) begin : g_db
      logic [5:0] gap_ff;
      logic       last_ff;
      logic       db_on;
      assign db_on = mode_w[2*p][MM_DEADBAND] && pair_buffer_enable_in[p] &&
                     deadband_ff[DB_LEN_HI:DB_LEN_LO] != 6'h00;
      always_ff @(posedge mclk_in or negedge rst_n_in) begin
         if (!rst_n_in) begin
            gap_ff  <= 6'h00;
            last_ff <= 1'b0;
         end else begin
            last_ff <= raw_v[2*p];
            if (db_on && raw_v[2*p] != last_ff) begin
               gap_ff <= deadband_ff[DB_LEN_HI:DB_LEN_LO];
            end else if (gap_ff != 6'h00 && presc_tick) begin
               gap_ff <= gap_ff - 6'h01;
            end
         end
      end
      always_comb begin
         if (db_on) begin
            db_pin_v[2*p]  = raw_v[2*p] && gap_ff == 6'h00 &&
                             raw_v[2*p] == last_ff;
            db_low_v[p]    = !raw_v[2*p] && gap_ff == 6'h00 &&
                             raw_v[2*p] == last_ff;
         end else begin
            db_pin_v[2*p]  = raw_v[2*p];
            db_low_v[p]    = !raw_v[2*p];
         end
      end
      assign db_pin_v[2*p+1] = raw_v[2*p+1];
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         module_output_pin_out <= '0;
         deadband_low_out      <= 3'h0;
      end else begin
         module_output_pin_out <= db_pin_v;
         deadband_low_out      <= db_low_v;
      end
   end

   // ***************************************************************
   // Read back
   // ***************************************************************
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sfr_rdata_out <= 8'h00;
      end else if (sfr_rd_in) begin
         sfr_rdata_out <= 8'h00;
         if (sfr_addr_in == ADDR_DEADBAND) sfr_rdata_out <= deadband_ff;
         if (sfr_addr_in == ADDR_CTRL) sfr_rdata_out <= {2'h0, match_flag_ff};
         for (int k = 0; k < NUM_MOD; k++) begin
            if (sfr_addr_in == ADDR_MODE + 8'(k))   sfr_rdata_out <= mode_w[k];
            if (sfr_addr_in == ADDR_CMP_LO + 8'(k)) sfr_rdata_out <= clo_w[k];
            if (sfr_addr_in == ADDR_AUX + 8'(k))    sfr_rdata_out <= aux_w[k];
            if (sfr_addr_in == ADDR_CMP_HI + 8'(k)) sfr_rdata_out <= chi_w[k];
         end
      end
   end

   // ***************************************************************
   // Assertions
   // ***************************************************************
   property p_flag_set;
      @(posedge mclk_in) disable iff (!rst_n_in)
      match_v[0] |=> match_flag_ff[0];
   endproperty
   a_flag_set: assert property (p_flag_set)
      else $error("match flag not set after match");

   property p_flag_hold;
      @(posedge mclk_in) disable iff (!rst_n_in)
      !(sfr_wr_in && sfr_addr_in == ADDR_CTRL) |=>
         (match_flag_ff & ~$past(match_v)) ==
         ($past(match_flag_ff) & ~$past(match_v));
   endproperty
   a_flag_hold: assert property (p_flag_hold)
      else $error("match flag changed without cause");

   property p_irq;
      @(posedge mclk_in) disable iff (!rst_n_in)
      match_irq_out |-> $past((match_flag_ff[0] && mode_w[0][MM_IRQ]) ||
         (match_flag_ff[1] && mode_w[1][MM_IRQ]) ||
         (match_flag_ff[2] && mode_w[2][MM_IRQ]) ||
         (match_flag_ff[3] && mode_w[3][MM_IRQ]) ||
         (match_flag_ff[4] && mode_w[4][MM_IRQ]) ||
         (match_flag_ff[5] && mode_w[5][MM_IRQ]));
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt without enabled flag");

   property p_inhibit;
      @(posedge mclk_in) disable iff (!rst_n_in)
      sfr_wr_in && sfr_addr_in == ADDR_CMP_LO |=> !mode_w[0][MM_COMPARATOR];
   endproperty
   a_inhibit: assert property (p_inhibit)
      else $error("comparator not inhibited by low write");

   property p_resume;
      @(posedge mclk_in) disable iff (!rst_n_in)
      sfr_wr_in && sfr_addr_in == ADDR_CMP_HI |=> mode_w[0][MM_COMPARATOR];
   endproperty
   a_resume: assert property (p_resume)
      else $error("comparator not resumed by high write");

   property p_no_match_off;
      @(posedge mclk_in) disable iff (!rst_n_in)
      !mode_w[2][MM_COMPARATOR] |-> !match_v[2];
   endproperty
   a_no_match_off: assert property (p_no_match_off)
      else $error("match while comparator off");

   property p_reload;
      @(posedge mclk_in) disable iff (!rst_n_in)
      low_wrap && !sfr_wr_in |=>
         act9_w[1] == {$past(aux_w[1][AUX_RELOAD9]), $past(chi_w[1])};
   endproperty
   a_reload: assert property (p_reload)
      else $error("active value not reloaded on wrap");

   property p_buffer_copy;
      @(posedge mclk_in) disable iff (!rst_n_in)
      pair_buffer_enable_in[0] && counter_overflow_in |=>
         clo_w[0] == $past(clo_w[1]) && chi_w[0] == $past(chi_w[1]);
   endproperty
   a_buffer_copy: assert property (p_buffer_copy)
      else $error("buffered compare not copied");

   property p_toggle;
      @(posedge mclk_in) disable iff (!rst_n_in)
      match_v[3] && mode_w[3][MM_TOGGLE] && !mode_w[3][MM_PULSE] &&
      !(sfr_wr_in && sfr_addr_in == ADDR_AUX + 8'h03) ##1 1'b1 |=>
         $changed(module_output_pin_out[3]);
   endproperty
   a_toggle: assert property (p_toggle)
      else $error("output did not toggle on match");

   property p_db_off;
      @(posedge mclk_in) disable iff (!rst_n_in)
      !pair_buffer_enable_in[1] |=>
         deadband_low_out[1] == !module_output_pin_out[2];
   endproperty
   a_db_off: assert property (p_db_off)
      else $error("dead band active without pair buffer");

   c_pwm8: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
      mode_w[0][MM_PULSE] && low_wrap);
   c_toggle: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
      match_v[3] && mode_w[3][MM_TOGGLE]);
   c_irq: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
      match_irq_out);
   c_wide_wrap: cover property (@(posedge mclk_in) disable iff (!rst_n_in)
      g_mod[4].res_wrap);
endmodule

//--- testbench/pwm_load.sv
// External load on the module output pins: counts high cycles of one pin.
// Assumes pins are sampled on the same clock as the block.
`timescale 1ns/1ps

module pwm_load (
   input  wire logic       mclk_in,
   input  wire logic       count_en_in,
   input  wire logic [2:0] watch_sel_in,
   input  wire logic [5:0] pin_in,
   output      logic [8:0] high_cycles_out
);
   // ************
   // Duty counter
   // ************
   logic en_d = 1'b0;
   // Restarts on a rising enable and holds the total once disabled,
   // so the bench can read it after the window has closed
   always @(posedge mclk_in) begin
      en_d <= count_en_in;
      if (count_en_in && !en_d) begin
         high_cycles_out <= {8'h00, pin_in[watch_sel_in] === 1'b1};
      end else if (count_en_in && pin_in[watch_sel_in] === 1'b1) begin
         high_cycles_out <= high_cycles_out + 9'h001;
      end
   end
endmodule

//--- testbench/six_channel_compare_pwm_modules_bench.sv
// Self-checking bench for the six-module compare/PWM block.
// Assumes pwm_pkg is compiled first; the bench plays counter and software.
`timescale 1ns/1ps

module six_channel_compare_pwm_modules_bench;
   import pwm_pkg::*;
   typedef struct {int sel; logic [8:0] exp;} chk_t;
   logic       mclk_in = 1'b0;
   logic       rst_n_in = 1'b0;
   logic [7:0] sfr_addr_in = 8'h00;
   logic [7:0] sfr_wdata_in = 8'h00;
   logic       sfr_wr_in = 1'b0;
   logic       sfr_rd_in = 1'b0;
   logic [7:0] sfr_rdata_out;
   logic [15:0] base_count_in = 16'h0000;
   logic       counter_overflow_in = 1'b0;
   logic       manual_reload_strobe_in = 1'b0;
   logic [2:0] pair_buffer_enable_in = 3'h0;
   logic [5:0] port_data_in = 6'h00;
   logic [5:0] module_output_pin_out;
   logic [2:0] deadband_low_out;
   logic       match_irq_out;
   logic       load_en = 1'b0;
   logic [8:0] high_cycles;
   logic [5:0] rnd;
   logic [7:0] rd_q[$];
   chk_t       out_q[$];
   logic       rd_pend = 1'b0;
   int         fail_count = 0;
   int         comparisons = 0;

   always #4 mclk_in = ~mclk_in;

   pwm_six dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
      .sfr_addr_in(sfr_addr_in), .sfr_wdata_in(sfr_wdata_in),
      .sfr_wr_in(sfr_wr_in), .sfr_rd_in(sfr_rd_in),
      .sfr_rdata_out(sfr_rdata_out), .base_count_in(base_count_in),
      .counter_overflow_in(counter_overflow_in),
      .manual_reload_strobe_in(manual_reload_strobe_in),
      .pair_buffer_enable_in(pair_buffer_enable_in),
      .port_data_in(port_data_in),
      .module_output_pin_out(module_output_pin_out),
      .deadband_low_out(deadband_low_out), .match_irq_out(match_irq_out));

   pwm_load load (.mclk_in(mclk_in), .count_en_in(load_en),
      .watch_sel_in(3'h2), .pin_in(module_output_pin_out),
      .high_cycles_out(high_cycles));

   // *****************
   // Drivers and tasks
   // *****************
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge mclk_in);
      sfr_addr_in <= a;
      sfr_wdata_in <= d;
      sfr_wr_in <= 1'b1;
      @(posedge mclk_in);
      sfr_wr_in <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge mclk_in);
      rd_q.push_back(e);
      sfr_addr_in <= a;
      sfr_rd_in <= 1'b1;
      @(posedge mclk_in);
      sfr_rd_in <= 1'b0;
   endtask
   task automatic cnt(input logic [15:0] v);
      @(posedge mclk_in);
      base_count_in <= v;
   endtask
   // Selector 0..5 is a pin, 6 the request, 7 the load's duty count,
   // 8..10 the low sides of the dead-band pairs
   task automatic out(input int sel, input logic [8:0] e);
      repeat (3) @(posedge mclk_in);
      out_q.push_back('{sel, e});
   endtask
   task automatic sweep();
      for (int i = 0; i < 256; i++) cnt(16'(i));
   endtask
   task automatic cmp_rd(input logic [7:0] e);
      comparisons++;
      if (sfr_rdata_out !== e) begin
         fail_count++;
         $display("ERROR read data exp %h seen %h", e, sfr_rdata_out);
      end
   endtask
   task automatic cmp_out(input chk_t c);
      logic [8:0] seen;
      seen = (c.sel >= 8) ? {8'h00, deadband_low_out[c.sel-8]} :
             (c.sel == 7) ? high_cycles : (c.sel == 6) ?
             {8'h00, match_irq_out} : {8'h00, module_output_pin_out[c.sel]};
      comparisons++;
      if (seen !== c.exp) begin
         fail_count++;
         $display("ERROR output %0d exp %h seen %h", c.sel, c.exp, seen);
      end
   endtask
   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   always @(negedge mclk_in) begin
      if (rd_pend) cmp_rd(rd_q.pop_front());
      rd_pend = sfr_rd_in;
      if (out_q.size() > 0) cmp_out(out_q.pop_front());
   end

   initial begin
      repeat (20000) @(posedge mclk_in);
      fail_count++;
      wrap_up();
   end

   // *************
   // Test sequence
   // *************
   initial begin
      void'($urandom(32'h826B));
      repeat (10) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         rd(ADDR_MODE + 8'(i), RST_REG);
         rd(ADDR_CMP_LO + 8'(i), RST_REG);
         rd(ADDR_AUX + 8'(i), RST_REG);
         rd(ADDR_CMP_HI + 8'(i), RST_REG);
      end
      rd(ADDR_DEADBAND, RST_REG);
      rd(8'h00, 8'h00);
      wr(ADDR_MODE + 8'h05, 8'hFF);
      rd(ADDR_MODE + 8'h05, 8'hCF);
      wr(ADDR_AUX + 8'h05, 8'hC7);
      rd(ADDR_AUX + 8'h05, 8'hC7);
      wr(ADDR_MODE + 8'h05, 8'h00);
      wr(ADDR_AUX + 8'h05, 8'h00);
      wr(ADDR_DEADBAND, 8'hA5);
      rd(ADDR_DEADBAND, 8'hA5);
      rnd = 6'($urandom());
      port_data_in <= rnd;
      for (int i = 0; i < 6; i++) out(i, {8'h00, rnd[i]});
      $display("test registers done");
      wr(ADDR_MODE, 8'h48);
      wr(ADDR_CMP_LO, 8'h34);
      rd(ADDR_MODE, 8'h08);
      wr(ADDR_CMP_HI, 8'h12);
      rd(ADDR_MODE, 8'h48);
      wr(ADDR_CMP_LO, 8'h34);
      wr(ADDR_MODE, 8'h49);
      cnt(16'h1233);
      cnt(16'h1234);
      out(6, 9'h001);
      rd(ADDR_CTRL, 8'h01);
      wr(ADDR_CTRL, 8'h3E);
      rd(ADDR_CTRL, 8'h00);
      out(6, 9'h000);
      wr(ADDR_MODE, 8'h48);
      cnt(16'h0000);
      cnt(16'h1234);
      rd(ADDR_CTRL, 8'h01);
      out(6, 9'h000);
      wr(ADDR_CTRL, 8'h3E);
      wr(ADDR_MODE, 8'h08);
      cnt(16'h0000);
      cnt(16'h1234);
      rd(ADDR_CTRL, 8'h00);
      $display("test timer done");
      wr(ADDR_CMP_LO + 8'h03, 8'h10);
      wr(ADDR_CMP_HI + 8'h03, 8'h00);
      wr(ADDR_MODE + 8'h03, 8'h4C);
      cnt(16'h0010);
      out(3, 9'h001);
      cnt(16'h0000);
      cnt(16'h0010);
      out(3, 9'h000);
      $display("test toggle done");
      pair_buffer_enable_in <= 3'h3;
      wr(ADDR_MODE + 8'h01, 8'h48);
      wr(ADDR_CMP_LO + 8'h01, 8'hCD);
      rd(ADDR_MODE + 8'h01, 8'h48);
      wr(ADDR_CMP_HI + 8'h01, 8'hAB);
      @(posedge mclk_in);
      counter_overflow_in <= 1'b1;
      @(posedge mclk_in);
      counter_overflow_in <= 1'b0;
      rd(ADDR_CMP_LO, 8'hCD);
      rd(ADDR_CMP_HI, 8'hAB);
      wr(ADDR_CMP_LO + 8'h03, 8'h5A);
      @(posedge mclk_in);
      manual_reload_strobe_in <= 1'b1;
      @(posedge mclk_in);
      manual_reload_strobe_in <= 1'b0;
      rd(ADDR_CMP_LO + 8'h02, 8'h5A);
      pair_buffer_enable_in <= 3'h0;
      $display("test buffer done");
      wr(ADDR_AUX + 8'h02, 8'h00);
      wr(ADDR_CMP_LO + 8'h02, 8'h00);
      wr(ADDR_CMP_HI + 8'h02, 8'h40);
      wr(ADDR_MODE + 8'h02, 8'h42);
      sweep();
      cnt(16'h0000);
      cnt(16'h003F);
      out(2, 9'h000);
      cnt(16'h0040);
      out(2, 9'h001);
      sweep();
      load_en <= 1'b1;
      sweep();
      load_en <= 1'b0;
      out(7, 9'h0C0);
      wr(ADDR_AUX + 8'h02, 8'h04);
      cnt(16'h003F);
      out(2, 9'h001);
      wr(ADDR_AUX + 8'h02, 8'h02);
      wr(ADDR_CMP_HI + 8'h02, 8'h00);
      sweep();
      cnt(16'h0000);
      cnt(16'h00FF);
      out(2, 9'h000);
      $display("test pwm8 done");
      wr(ADDR_CMP_LO + 8'h04, 8'h00);
      wr(ADDR_CMP_HI + 8'h04, 8'h02);
      wr(ADDR_MODE + 8'h04, 8'h42);
      for (int r = 1; r < 4; r++) begin
         wr(ADDR_AUX + 8'h04, {2'(r), 6'h00});
         cnt(16'hF1FF);
         out(4, {8'h00, r == 3});
         cnt(16'h0200);
         out(4, 9'h001);
      end
      $display("test wide pwm done");
      wr(ADDR_DEADBAND, 8'h03);
      pair_buffer_enable_in <= 3'h1;
      wr(ADDR_MODE, 8'hC2);
      out(0, 9'h000);
      out(8, 9'h001);
      cnt(16'h02FF);
      out(0, 9'h000);
      out(0, 9'h001);
      out(8, 9'h000);
      $display("test dead band done");
      wrap_up();
   end
endmodule
